// >>> uart_pin_defines.vh
`ifndef UART_PIN_DEFINES_VH
`define UART_PIN_DEFINES_VH

// ****************************************
// alternate function register fields
// ****************************************
`define AFR_BCAST_BIT 0
`define AFR_MF_SEL_LO 1
`define AFR_MF_SEL_HI 2
`define MF_SEL_OP2 2'h0
`define MF_SEL_BAUD 2'h1
`define MF_SEL_RXRDY 2'h2

// ****************************************
// modem control register fields
// ****************************************
`define MCR_RTS_BIT 1
`define MCR_OP2_BIT 3
`define MCR_IR_BIT 6
`define MCR_RESET 8'h08

// ****************************************
// feature and enhanced feature fields
// ****************************************
`define FEATURE_CONTROL_REG_RX_INV_BIT 2
`define EFR_AUTO_RTS_BIT 6
`define EFR_AUTO_CTS_BIT 7

// ****************************************
// timing
// ****************************************
`define CLK_PERIOD_NS 50
`define RESET_MIN_NS 40
`define RESET_MIN_CYCLES \
    ((`RESET_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SYNC_STAGES 2

`endif

// >>> pin_sync.v
`timescale 1ns/10ps

// ****************************************
// two flip-flop synchroniser
// ****************************************
module pin_sync #(
    parameter WIDTH = 1,
    parameter [WIDTH-1:0] RESET_VALUE = {WIDTH{1'b1}}
) (
    input wire ref_clk,
    input wire reset_n,
    input wire [WIDTH-1:0] pin_in,
    output reg [WIDTH-1:0] sync_out
);

reg [WIDTH-1:0] stage1;

// first stage feeds only the second stage
always @(posedge ref_clk) begin
    if (!reset_n) begin
        stage1 <= RESET_VALUE;
        sync_out <= RESET_VALUE;
    end else begin
        stage1 <= pin_in;
        sync_out <= stage1;
    end
end

endmodule // pin_sync

// >>> uart_chan_pins.v
`timescale 1ns/10ps
`include "uart_pin_defines.vh"

// ****************************************
// per-channel pin function logic
// ****************************************
module uart_chan_pins (
    input wire ref_clk,
    input wire reset_n,
    input wire mcr_load,
    input wire [7:0] mcr_data,
    input wire [2:0] alternate_function_reg,
    input wire [7:0] feature_control_reg,
    input wire [7:0] enhanced_feature_reg,
    input wire int_request,
    input wire tx_fifo_ready,
    input wire rx_fifo_ready,
    input wire baud16_clk,
    input wire tx_serial,
    input wire tx_ir_pulse,
    input wire auto_rts_assert,
    input wire serial_in,
    input wire clear_send_n,
    output reg irq,
    output reg tx_ready_n,
    output reg multi_func_out_n,
    output reg serial_out,
    output reg request_send_n,
    output reg rx_serial,
    output reg rx_ir,
    output reg tx_flow_hold,
    output reg clear_send_level,
    output reg [7:0] modem_control_reg
);

wire rx_sync;
wire cts_sync_n;
wire irda_mode;
wire [1:0] mf_sel;
reg next_mf;

assign irda_mode = modem_control_reg[`MCR_IR_BIT];
assign mf_sel = alternate_function_reg[`AFR_MF_SEL_HI:`AFR_MF_SEL_LO];

// synchronise receive and clear-to-send pins
pin_sync #(.WIDTH(2), .RESET_VALUE(2'h3)) u_sync (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .pin_in({serial_in, clear_send_n}),
    .sync_out({rx_sync, cts_sync_n})
);

// modem control copy, bit 3 set at reset
always @(posedge ref_clk) begin
    if (!reset_n) begin
        modem_control_reg <= `MCR_RESET; // R7
    end else if (mcr_load) begin
        modem_control_reg <= mcr_data;
    end
end

// multi-function output select
always @* begin
    case (mf_sel) // R5
        `MF_SEL_OP2: next_mf = ~modem_control_reg[`MCR_OP2_BIT]; // R6
        `MF_SEL_BAUD: next_mf = ~baud16_clk; // R8
        `MF_SEL_RXRDY: next_mf = ~rx_fifo_ready; // R9
        default: next_mf = 1'b1;
    endcase
end

// registered pin outputs
always @(posedge ref_clk) begin
    if (!reset_n) begin
        irq <= 1'b0;
        tx_ready_n <= 1'b1;
        multi_func_out_n <= 1'b1;
        serial_out <= 1'b1; // R17
        request_send_n <= 1'b1;
        rx_serial <= 1'b1; // R17
        rx_ir <= 1'b0;
        tx_flow_hold <= 1'b0;
        clear_send_level <= 1'b0;
    end else begin
        irq <= int_request; // R3
        tx_ready_n <= ~tx_fifo_ready; // R4
        multi_func_out_n <= next_mf;
        if (irda_mode) begin
            serial_out <= ~tx_serial & tx_ir_pulse; // R11
        end else begin
            serial_out <= tx_serial; // R10
        end
        // receive path steered by signalling mode
        rx_serial <= irda_mode ? 1'b1 : rx_sync;
        rx_ir <= irda_mode ?
            (rx_sync ^ feature_control_reg[`FEATURE_CONTROL_REG_RX_INV_BIT]) : 1'b0; // R13
        if (enhanced_feature_reg[`EFR_AUTO_RTS_BIT]) begin
            request_send_n <= ~(modem_control_reg[`MCR_RTS_BIT] &
                auto_rts_assert);
        end else begin
            request_send_n <= ~modem_control_reg[`MCR_RTS_BIT]; // R18
        end
        tx_flow_hold <= enhanced_feature_reg[`EFR_AUTO_CTS_BIT] &
            cts_sync_n; // R15
        clear_send_level <= ~cts_sync_n;
    end
end

endmodule // uart_chan_pins

// >>> dual_uart_pin_function_logic.v
`timescale 1ns/10ps
`include "uart_pin_defines.vh"

// Behaviour
// R1: chip select low routes access to channel B on select low, A on high.
// R2: broadcast bit 0 makes one selected write reach both channels.
// R3: each channel drives its own active-high interrupt while requesting.
// R4: each channel drives active-low transmit-ready from its transmit status.
// R5: alternate function bits 1-2 choose one multi-function output role.
// R6: general output role drives pin low while modem control bit 3 is one.
// R7: modem control bit 3 is one after reset.
// R8: baud role presents the sixteen-times baud clock.
// R9: receive-ready role presents active-low receive-ready for DMA.
// R10: modem control bit 6 zero: standard signalling, transmit idles high.
// R11: modem control bit 6 one: infrared signalling, transmit rests low.
// R12: far end keeps receive line high when idle in standard mode.
// R13: feature control bit 2 inverts infrared receive pulses.
// R14: host asserts request-to-send before enabling automatic flow control.
// R15: enhanced feature bit 7 enables clear-to-send transmit flow control.
// R16: host selects with chip select low and three address lines.
// R17: reset clears outputs, holds transmit high, ignores receive input.
// R18: without automatic flow, request-to-send follows inverted control bit.
module dual_uart_pin_function_logic (
    input wire ref_clk,
    input wire reset_n,
    // host bus pins
    input wire chip_select_n,
    input wire channel_select,
    input wire [2:0] addr,
    input wire write_strobe_n,
    input wire read_strobe_n,
    input wire [7:0] data_in,
    output reg [7:0] data_out,
    output reg data_oe_n,
    // register file side
    output reg reg_write_a,
    output reg reg_write_b,
    output reg reg_read_a,
    output reg reg_read_b,
    output reg [2:0] reg_addr,
    output reg [7:0] reg_wdata,
    input wire [7:0] read_data_a,
    input wire [7:0] read_data_b,
    // channel a configuration
    input wire mcr_load_a,
    input wire [7:0] mcr_data_a,
    input wire [2:0] alternate_function_reg_a,
    input wire [7:0] feature_control_reg_a,
    input wire [7:0] enhanced_feature_reg_a,
    // channel b configuration
    input wire mcr_load_b,
    input wire [7:0] mcr_data_b,
    input wire [2:0] alternate_function_reg_b,
    input wire [7:0] feature_control_reg_b,
    input wire [7:0] enhanced_feature_reg_b,
    // channel a engine signals
    input wire int_request_a,
    input wire tx_fifo_ready_a,
    input wire rx_fifo_ready_a,
    input wire baud16_clk_a,
    input wire tx_serial_a,
    input wire tx_ir_pulse_a,
    input wire auto_rts_assert_a,
    output wire rx_serial_a,
    output wire rx_ir_a,
    output wire tx_flow_hold_a,
    output wire clear_send_level_a,
    output wire [7:0] modem_control_reg_a,
    // channel b engine signals
    input wire int_request_b,
    input wire tx_fifo_ready_b,
    input wire rx_fifo_ready_b,
    input wire baud16_clk_b,
    input wire tx_serial_b,
    input wire tx_ir_pulse_b,
    input wire auto_rts_assert_b,
    output wire rx_serial_b,
    output wire rx_ir_b,
    output wire tx_flow_hold_b,
    output wire clear_send_level_b,
    output wire [7:0] modem_control_reg_b,
    // channel a pins
    output wire irq_chan_a,
    output wire tx_ready_a_n,
    output wire multi_func_out_a_n,
    output wire serial_out_a,
    output wire request_send_a_n,
    input wire serial_in_a,
    input wire clear_send_a_n,
    // channel b pins
    output wire irq_chan_b,
    output wire tx_ready_b_n,
    output wire multi_func_out_b_n,
    output wire serial_out_b,
    output wire request_send_b_n,
    input wire serial_in_b,
    input wire clear_send_b_n
);

// ****************************************
// bus pin synchronisation
// ****************************************
localparam BUS_W = 16;
localparam [BUS_W-1:0] BUS_RESET = 16'hf000;

wire [BUS_W-1:0] bus_sync;
wire cs_s_n;
wire channel_select_s;
wire wr_s_n;
wire rd_s_n;
wire [2:0] addr_s;
wire [7:0] data_s;
reg wr_prev_n;
reg rd_prev_n;
wire write_done;
wire read_start;
wire selected;
wire broadcast;
wire any_write;
wire any_read;
reg next_write_a;
reg next_write_b;
reg next_read_a;
reg next_read_b;
reg [7:0] next_data;

// all host pins pass two flip-flops
pin_sync #(.WIDTH(BUS_W), .RESET_VALUE(BUS_RESET)) u_bus_sync (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .pin_in({chip_select_n, channel_select, write_strobe_n, read_strobe_n,
        1'b0, addr, data_in}),
    .sync_out(bus_sync)
);

assign cs_s_n = bus_sync[15];
assign channel_select_s = bus_sync[14];
assign wr_s_n = bus_sync[13];
assign rd_s_n = bus_sync[12];
assign addr_s = bus_sync[10:8];
assign data_s = bus_sync[7:0];

// ****************************************
// strobe edges and channel decode
// ****************************************

// previous strobe levels for edge detection
always @(posedge ref_clk) begin
    if (!reset_n) begin
        wr_prev_n <= 1'b1;
        rd_prev_n <= 1'b1;
    end else begin
        wr_prev_n <= wr_s_n;
        rd_prev_n <= rd_s_n;
    end
end

// write completes on rising strobe, read starts on falling
assign write_done = wr_s_n & ~wr_prev_n;
assign read_start = ~rd_s_n & rd_prev_n;
assign selected = ~cs_s_n; // R16
assign broadcast = alternate_function_reg_a[`AFR_BCAST_BIT] |
    alternate_function_reg_b[`AFR_BCAST_BIT];

// decode which channel strobes fire, write wins over read
always @* begin
    next_write_a = 1'b0;
    next_write_b = 1'b0;
    next_read_a = 1'b0;
    next_read_b = 1'b0;
    if (selected && write_done) begin
        if (broadcast) begin
            next_write_a = 1'b1; // R2
            next_write_b = 1'b1; // R2
        end else begin
            next_write_a = channel_select_s; // R1
            next_write_b = ~channel_select_s; // R1
        end
    end else if (selected && read_start) begin
        next_read_a = channel_select_s; // R1
        next_read_b = ~channel_select_s; // R1
    end
end

// any channel taking the access this cycle
assign any_write = next_write_a | next_write_b;
assign any_read = next_read_a | next_read_b;

// one-cycle register strobes toward the channels
always @(posedge ref_clk) begin
    if (!reset_n) begin
        reg_write_a <= 1'b0;
        reg_write_b <= 1'b0;
        reg_read_a <= 1'b0;
        reg_read_b <= 1'b0;
        reg_addr <= 3'h0;
        reg_wdata <= 8'h00;
    end else begin
        reg_write_a <= next_write_a;
        reg_write_b <= next_write_b;
        reg_read_a <= next_read_a;
        reg_read_b <= next_read_b;
        if (any_write) begin
            reg_addr <= addr_s;
            reg_wdata <= data_s;
        end else if (any_read) begin
            reg_addr <= addr_s;
        end
    end
end

// ****************************************
// read data drive
// ****************************************

// read data source follows the synced channel select
always @* begin
    case (channel_select_s) // R1
        1'b1: next_data = read_data_a;
        1'b0: next_data = read_data_b;
        default: next_data = 8'h00;
    endcase
end

// drive the data bus while a selected read is active
always @(posedge ref_clk) begin
    if (!reset_n) begin
        data_out <= 8'h00;
        data_oe_n <= 1'b1;
    end else begin
        data_oe_n <= ~(selected & ~rd_s_n);
        data_out <= next_data;
    end
end

// ****************************************
// channel pin logic
// ****************************************

// channel a
uart_chan_pins u_chan_a (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .mcr_load(mcr_load_a),
    .mcr_data(mcr_data_a),
    .alternate_function_reg(alternate_function_reg_a),
    .feature_control_reg(feature_control_reg_a),
    .enhanced_feature_reg(enhanced_feature_reg_a),
    .int_request(int_request_a),
    .tx_fifo_ready(tx_fifo_ready_a),
    .rx_fifo_ready(rx_fifo_ready_a),
    .baud16_clk(baud16_clk_a),
    .tx_serial(tx_serial_a),
    .tx_ir_pulse(tx_ir_pulse_a),
    .auto_rts_assert(auto_rts_assert_a),
    .serial_in(serial_in_a),
    .clear_send_n(clear_send_a_n),
    .irq(irq_chan_a),
    .tx_ready_n(tx_ready_a_n),
    .multi_func_out_n(multi_func_out_a_n),
    .serial_out(serial_out_a),
    .request_send_n(request_send_a_n),
    .rx_serial(rx_serial_a),
    .rx_ir(rx_ir_a),
    .tx_flow_hold(tx_flow_hold_a),
    .clear_send_level(clear_send_level_a),
    .modem_control_reg(modem_control_reg_a)
);

// channel b
uart_chan_pins u_chan_b (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .mcr_load(mcr_load_b),
    .mcr_data(mcr_data_b),
    .alternate_function_reg(alternate_function_reg_b),
    .feature_control_reg(feature_control_reg_b),
    .enhanced_feature_reg(enhanced_feature_reg_b),
    .int_request(int_request_b),
    .tx_fifo_ready(tx_fifo_ready_b),
    .rx_fifo_ready(rx_fifo_ready_b),
    .baud16_clk(baud16_clk_b),
    .tx_serial(tx_serial_b),
    .tx_ir_pulse(tx_ir_pulse_b),
    .auto_rts_assert(auto_rts_assert_b),
    .serial_in(serial_in_b),
    .clear_send_n(clear_send_b_n),
    .irq(irq_chan_b),
    .tx_ready_n(tx_ready_b_n),
    .multi_func_out_n(multi_func_out_b_n),
    .serial_out(serial_out_b),
    .request_send_n(request_send_b_n),
    .rx_serial(rx_serial_b),
    .rx_ir(rx_ir_b),
    .tx_flow_hold(tx_flow_hold_b),
    .clear_send_level(clear_send_level_b),
    .modem_control_reg(modem_control_reg_b)
);

endmodule // dual_uart_pin_function_logic

// >>> dual_uart_pin_props.sv
`timescale 1ns/10ps
// ****
// channel a pin checker
// ****
module dual_uart_pin_props (
    input wire ref_clk,
    input wire reset_n,
    input wire chip_select_n,
    input wire channel_select,
    input wire write_strobe_n,
    input wire reg_write_a,
    input wire reg_write_b,
    input wire [2:0] alternate_function_reg_a,
    input wire [2:0] alternate_function_reg_b,
    input wire [7:0] enhanced_feature_reg_a,
    input wire [7:0] modem_control_reg_a,
    input wire int_request_a,
    input wire tx_fifo_ready_a,
    input wire rx_fifo_ready_a,
    input wire baud16_clk_a,
    input wire tx_serial_a,
    input wire tx_ir_pulse_a,
    input wire irq_chan_a,
    input wire tx_ready_a_n,
    input wire multi_func_out_a_n,
    input wire serial_out_a,
    input wire request_send_a_n
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    // broadcast from either channel, multi-function role of a
    wire bcast = alternate_function_reg_a[0] | alternate_function_reg_b[0];
    wire [1:0] mf_sel = alternate_function_reg_a[2:1];
    // write strobe rising at the pins while selected
    sequence wr_rise;
        !write_strobe_n && !chip_select_n ##1
        write_strobe_n && !chip_select_n;
    endsequence
    sequence one_chan;
        channel_select ? (reg_write_a && !reg_write_b)
            : (reg_write_b && !reg_write_a);
    endsequence
    a_route_by_select: assert property (wr_rise ##0 !bcast |-> ##[1:4] one_chan)
        else $error("write routed wrong");
    a_bcast_both: assert property (wr_rise ##0 bcast |-> ##[1:4] reg_write_a && reg_write_b)
        else $error("broadcast missed a channel");
    a_irq_follows: assert property ($past(reset_n) && $stable(int_request_a) |-> irq_chan_a == int_request_a)
        else $error("interrupt level wrong");
    a_txrdy_low: assert property ($past(reset_n) && $stable(tx_fifo_ready_a) |-> tx_ready_a_n == !tx_fifo_ready_a)
        else $error("tx ready level wrong");
    a_op2_low: assert property (mf_sel == 2'h0 && modem_control_reg_a[3] |=> !multi_func_out_a_n)
        else $error("general output not low");
    a_baud_out: assert property (mf_sel == 2'h1 |=> multi_func_out_a_n == !$past(baud16_clk_a))
        else $error("baud clock not on pin");
    a_rxrdy_out: assert property (mf_sel == 2'h2 && rx_fifo_ready_a |=> !multi_func_out_a_n)
        else $error("rx ready not on pin");
    a_mcr_reset: assert property ($rose(reset_n) |-> modem_control_reg_a[3])
        else $error("modem bit 3 clear after reset");
    a_tx_std: assert property (!modem_control_reg_a[6] |=> serial_out_a == $past(tx_serial_a))
        else $error("standard tx wrong");
    a_tx_ir_rest: assert property (modem_control_reg_a[6] && !tx_ir_pulse_a |=> !serial_out_a)
        else $error("infrared tx not resting low");
    a_rts_general: assert property (!enhanced_feature_reg_a[6] && modem_control_reg_a[1] |=> !request_send_a_n)
        else $error("rts not following modem bit");
endmodule // dual_uart_pin_props

bind dual_uart_pin_function_logic dual_uart_pin_props props_inst (.*);

// >>> serial_far_end.sv
`timescale 1ns/10ps
// ****
// far-end serial transceivers
// ****
module serial_far_end (
    input wire logic sending,
    input wire logic line,
    input wire logic ir,
    input wire logic cts_n,
    output logic serial_in_a,
    output logic serial_in_b,
    output logic clear_send_a_n,
    output logic clear_send_b_n
);
    // line rests at the idle level of its mode when not sending
    assign serial_in_a = sending ? line : !ir;
    assign serial_in_b = sending ? line : !ir;
    assign clear_send_a_n = cts_n;
    assign clear_send_b_n = cts_n;
endmodule // serial_far_end

// >>> test_dual_uart_pin_function_logic.sv
`timescale 1ns/10ps
// ****
// pin function testbench
// ****
module test_dual_uart_pin_function_logic;
    logic ref_clk, reset_n, chip_select_n, channel_select, data_oe_n;
    logic write_strobe_n, read_strobe_n, reg_write_a, reg_write_b;
    logic reg_read_a, reg_read_b, mcr_load_a, mcr_load_b;
    logic [2:0] addr, reg_addr, alternate_function_reg_a, alternate_function_reg_b;
    logic [7:0] data_in, data_out, reg_wdata, read_data_a, read_data_b;
    logic [7:0] mcr_data_a, mcr_data_b, modem_control_reg_a, modem_control_reg_b;
    logic [7:0] feature_control_reg_a, feature_control_reg_b;
    logic [7:0] enhanced_feature_reg_a, enhanced_feature_reg_b;
    logic int_request_a, tx_fifo_ready_a, rx_fifo_ready_a, baud16_clk_a;
    logic int_request_b, tx_fifo_ready_b, rx_fifo_ready_b, baud16_clk_b;
    logic tx_serial_a, tx_ir_pulse_a, auto_rts_assert_a;
    logic tx_serial_b, tx_ir_pulse_b, auto_rts_assert_b;
    logic rx_serial_a, rx_ir_a, tx_flow_hold_a, clear_send_level_a;
    logic rx_serial_b, rx_ir_b, tx_flow_hold_b, clear_send_level_b;
    logic irq_chan_a, tx_ready_a_n, multi_func_out_a_n, serial_out_a;
    logic irq_chan_b, tx_ready_b_n, multi_func_out_b_n, serial_out_b;
    logic request_send_a_n, serial_in_a, clear_send_a_n;
    logic request_send_b_n, serial_in_b, clear_send_b_n;
    logic sending, line, ir, cts_n, lv;
    logic [6:0] eng_a, eng_b;
    logic [7:0] mtab [4] = '{8'h08, 8'h00, 8'h4a, 8'h42};
    logic [6:0] etab [4] = '{7'h55, 7'h2a, 7'h7f, 7'h00};
    int error_cnt, n_checks;
    // engine levels packed for table-driven stimulus
    assign {int_request_a, tx_fifo_ready_a, rx_fifo_ready_a, baud16_clk_a,
        tx_serial_a, tx_ir_pulse_a, auto_rts_assert_a} = eng_a;
    assign {int_request_b, tx_fifo_ready_b, rx_fifo_ready_b, baud16_clk_b,
        tx_serial_b, tx_ir_pulse_b, auto_rts_assert_b} = eng_b;
    wire [4:0] pa = {irq_chan_a, tx_ready_a_n, multi_func_out_a_n,
        serial_out_a, request_send_a_n};
    wire [4:0] pb = {irq_chan_b, tx_ready_b_n, multi_func_out_b_n,
        serial_out_b, request_send_b_n};

    dual_uart_pin_function_logic dual_uart_pin_function_logic_inst (.*);
    serial_far_end serial_far_end_inst (.*);

    // 20 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    // ****
    // tasks
    // ****
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge ref_clk);
            #5;
        end
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // expected pins: irq, tx ready, multi-function, serial out, rts
    function automatic logic [4:0] pins(input logic [6:0] e,
        input logic [7:0] m, input logic [1:0] s, input logic f);
        logic mf;
        mf = s == 2'h0 ? !m[3] : s == 2'h1 ? !e[3] : s == 2'h2 ? !e[4] : 1'b1;
        pins = {e[6], !e[5], mf, m[6] ? !e[2] & e[1] : e[2],
            f ? !(m[1] & e[0]) : !m[1]};
    endfunction
    task automatic set_mcr(input logic [7:0] ma, input logic [7:0] mb);
        mcr_data_a = ma;
        mcr_data_b = mb;
        mcr_load_a = 1'b1;
        mcr_load_b = 1'b1;
        tick(1);
        mcr_load_a = 1'b0;
        mcr_load_b = 1'b0;
        tick(1);
        chk(modem_control_reg_a, ma);
        chk(modem_control_reg_b, mb);
    endtask
    task automatic bus_wr(input logic cs, input logic sel, input logic [2:0] a,
        input logic [7:0] d, input logic [1:0] exp);
        logic [1:0] got;
        got = 2'h0;
        chip_select_n = cs;
        channel_select = sel;
        addr = a;
        data_in = d;
        write_strobe_n = 1'b0;
        tick(4);
        write_strobe_n = 1'b1;
        repeat (8) begin
            tick(1);
            got = got | {reg_write_a, reg_write_b};
            if ((reg_write_a | reg_write_b) === 1'b1) begin
                chk({5'h0, reg_addr}, {5'h0, a});
                chk(reg_wdata, d);
            end
        end
        chip_select_n = 1'b1;
        tick(3);
        chk({6'h0, got}, {6'h0, exp});
    endtask
    task automatic bus_rd(input logic sel, input logic [7:0] exp);
        logic [1:0] got;
        got = 2'h0;
        chip_select_n = 1'b0;
        channel_select = sel;
        read_strobe_n = 1'b0;
        repeat (5) begin
            tick(1);
            got = got | {reg_read_a, reg_read_b};
        end
        chk({7'h0, data_oe_n}, 8'h00);
        chk(data_out, exp);
        chk({6'h0, got}, {6'h0, sel, !sel});
        read_strobe_n = 1'b1;
        chip_select_n = 1'b1;
        tick(4);
        chk({7'h0, data_oe_n}, 8'h01);
    endtask
    task automatic report_and_stop;
        $display("Checks %0d, errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // ****
    // main sequence
    // ****
    initial begin
        {reset_n, write_strobe_n, read_strobe_n, chip_select_n} = 4'h7;
        {channel_select, addr, data_in, mcr_load_a, mcr_load_b} = 13'h0;
        {mcr_data_a, mcr_data_b, feature_control_reg_a} = 24'h0;
        {feature_control_reg_b, enhanced_feature_reg_a} = 16'h0;
        {enhanced_feature_reg_b, alternate_function_reg_a} = 11'h0;
        alternate_function_reg_b = 3'h0;
        {read_data_a, read_data_b} = 16'ha55a;
        {eng_a, eng_b} = 14'h3fff;
        {sending, line, ir, cts_n} = 4'h9;
        error_cnt = 0;
        n_checks = 0;
        tick(3);
        chk({2'h0, rx_serial_a, pa}, 8'h2f);
        chk(modem_control_reg_a, 8'h08);
        reset_n = 1'b1;
        // every role, mode and request-to-send flow setting on both channels
        for (int i = 0; i < 128; i++) begin
            eng_a = etab[i[1:0]];
            eng_b = ~etab[i[1:0]];
            alternate_function_reg_a = {i[3:2], 1'b0};
            alternate_function_reg_b = {~i[3:2], 1'b0};
            enhanced_feature_reg_a = {1'b0, i[4], 6'h0};
            enhanced_feature_reg_b = {1'b0, ~i[4], 6'h0};
            set_mcr(mtab[i[6:5]], mtab[i[6:5]] ^ 8'h40);
            chk({3'h0, pa}, {3'h0, pins(eng_a, mtab[i[6:5]], i[3:2], i[4])});
            chk({3'h0, pb}, {3'h0, pins(~etab[i[1:0]],
                mtab[i[6:5]] ^ 8'h40, ~i[3:2], ~i[4])});
        end
        // request-to-send raised before automatic flow is enabled
        set_mcr(8'h0a, 8'h0a);
        enhanced_feature_reg_a = 8'h40;
        tick(2);
        chk({7'h0, request_send_a_n}, {7'h0, !eng_a[0]});
        // receive paths and clear-to-send
        for (int j = 0; j < 16; j++) begin
            ir = j[0];
            sending = j[2];
            line = 1'b0;
            cts_n = j[3];
            feature_control_reg_a = {5'h0, j[1], 2'h0};
            feature_control_reg_b = {5'h0, j[1], 2'h0};
            enhanced_feature_reg_a = {j[0] ^ j[1], 7'h0};
            enhanced_feature_reg_b = {j[0] ^ j[1], 7'h0};
            set_mcr({1'b0, j[0], 6'h0}, {1'b0, j[0], 6'h0});
            tick(3);
            lv = sending ? 1'b0 : !ir;
            chk({4'h0, rx_serial_a, rx_ir_a, tx_flow_hold_a, clear_send_level_a},
                {4'h0, ir | lv, ir & (lv ^ j[1]), (j[0] ^ j[1]) & j[3], !j[3]});
            chk({4'h0, rx_serial_b, rx_ir_b, tx_flow_hold_b, clear_send_level_b},
                {4'h0, ir | lv, ir & (lv ^ j[1]), (j[0] ^ j[1]) & j[3], !j[3]});
        end
        alternate_function_reg_a = 3'h0;
        alternate_function_reg_b = 3'h0;
        bus_wr(1'b0, 1'b1, 3'h3, 8'h3c, 2'h2);
        bus_wr(1'b0, 1'b0, 3'h7, 8'hc3, 2'h1);
        bus_wr(1'b1, 1'b1, 3'h1, 8'h11, 2'h0);
        alternate_function_reg_b = 3'h1;
        bus_wr(1'b0, 1'b0, 3'h0, 8'hff, 2'h3);
        alternate_function_reg_b = 3'h0;
        alternate_function_reg_a = 3'h1;
        bus_wr(1'b0, 1'b1, 3'h5, 8'h00, 2'h3);
        alternate_function_reg_a = 3'h0;
        bus_rd(1'b1, 8'ha5);
        bus_rd(1'b0, 8'h5a);
        report_and_stop;
    end

    // hang guard, over twenty times the expected run
    initial begin
        #500000;
        error_cnt++;
        $display("Error at %0t: timeout", $time);
        report_and_stop;
    end
endmodule // test_dual_uart_pin_function_logic
